// File: hdl/bbrm_defines.svh
`ifndef BBRM_DEFINES_SVH
`define BBRM_DEFINES_SVH

// Parameter table layout, word indices from the table pointer.
`define BBRM_TBL_WORDS 16
`define BBRM_TBL_FUNC 0
`define BBRM_TBL_DBASE 2
`define BBRM_TBL_DRAST 3
`define BBRM_TBL_DLX 4
`define BBRM_TBL_DTY 5
`define BBRM_TBL_DW 6
`define BBRM_TBL_DH 7
`define BBRM_TBL_SBASE 8
`define BBRM_TBL_SRAST 9
`define BBRM_TBL_SLX 10
`define BBRM_TBL_STY 11
`define BBRM_TBL_PAT0 12

// Function word fields, little-endian bit positions.
`define BBRM_FN_SRC_BANK 5
`define BBRM_FN_DST_BANK 4
`define BBRM_FN_SEL_HI 3
`define BBRM_FN_SEL_LO 2
`define BBRM_FN_OP_HI 1
`define BBRM_FN_OP_LO 0

// Source select and operation codes.
`define BBRM_SEL_BLOCK 2'h0
`define BBRM_SEL_COMPL 2'h1
`define BBRM_SEL_AND_PAT 2'h2
`define BBRM_SEL_PAT 2'h3
`define BBRM_OP_REPLACE 2'h0
`define BBRM_OP_PAINT 2'h1
`define BBRM_OP_INVERT 2'h2
`define BBRM_OP_ERASE 2'h3

// Reset values and fetch sequencing.
`define BBRM_WORD_RST 16'h0000
`define BBRM_FETCH_LAST 5'h11

`endif

// File: hdl/bbrm_pkg.sv
package bbrm_pkg;

    typedef logic [15:0] bbrm_word_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_FETCH = 4'h1,
        ST_CHECK = 4'h2,
        ST_LINE = 4'h3,
        ST_SRC0 = 4'h4,
        ST_SRC1 = 4'h5,
        ST_DST = 4'h6,
        ST_WAIT = 4'h7,
        ST_WRITE = 4'h8
    } bbrm_state_e;

endpackage : bbrm_pkg

// File: hdl/bbrm_comb_if.sv
interface bbrm_comb_if;
    import bbrm_pkg::*;
    bbrm_word_t src;
    bbrm_word_t dst;
    bbrm_word_t pat;
    bbrm_word_t mask;
    logic [1:0] src_sel;
    logic [1:0] op;
    bbrm_word_t res;
    modport eng (output src, dst, pat, mask, src_sel, op, input res);
    modport comb (input src, dst, pat, mask, src_sel, op, output res);
endinterface : bbrm_comb_if

// File: hdl/bbrm_combine.sv
`include "bbrm_defines.svh"

module bbrm_combine
    import bbrm_pkg::*;
(
    bbrm_comb_if.comb cif
);

    bbrm_word_t operand;
    bbrm_word_t merged;

    always_comb begin
        unique case (cif.src_sel)
            `BBRM_SEL_BLOCK: operand = cif.src;
            `BBRM_SEL_COMPL: operand = ~cif.src;
            `BBRM_SEL_AND_PAT: operand = cif.src & cif.pat;
            `BBRM_SEL_PAT: operand = cif.pat;
        endcase
    end

    always_comb begin
        unique case (cif.op)
            `BBRM_OP_REPLACE: merged = operand;
            `BBRM_OP_PAINT: merged = operand | cif.dst;
            `BBRM_OP_INVERT: merged = operand ^ cif.dst;
            `BBRM_OP_ERASE: merged = ~operand & cif.dst;
        endcase
    end

    // Bits outside the edge mask keep the old destination value.
    assign cif.res = (merged & cif.mask) | (cif.dst & ~cif.mask);

endmodule : bbrm_combine

// File: hdl/bbrm_top.sv
`include "bbrm_defines.svh"

// Functional notes
// - Only the table pointer accumulator is preserved; others end arbitrary.
// - Without writable control store the operation traps as unimplemented.
// - Sixteen-word parameter table: function, unused, destination, source, four patterns.
// - Negative destination width or height means no writes at all.
// - Interrupts accepted only at scan line start; progress saved, PC backed up.
// - Function word bank flags, source select and operation are all honoured.
// - Operation: replace, OR, XOR, or inverted source AND destination.
// - Source: block, complemented block, block AND pattern, or pattern.
// - One pattern word per processed line, rotating, aligned to destination words.
// - Bottom to top when destination below source, else top to bottom.
// - Source rectangle uses destination width and height.
// - Overlapping moves are ordered so results match an unmodified source copy.
// - Rectangles given by base, raster words, left x, top y; the destination also by width, height.
// - Roughly 13 cycles per stored word, 23 per moved word.
// - About 14-21 cycles per line change; about 240 cycles setup.
module bbrm_top
    import bbrm_pkg::*;
(
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // Instruction issue and accumulators.
    input wire logic start_i,
    input wire logic wcs_present_i,
    input wire logic irq_pending_i,
    input wire logic [15:0] progress_acc_i,
    input wire logic [15:0] table_ptr_acc_i,
    output logic busy_o,
    output logic done_o,
    output logic trap_o,
    output logic pc_backup_o,
    output logic [15:0] progress_acc_o,
    output logic [15:0] table_ptr_acc_o,
    // Main memory master port.
    output logic [15:0] mem_addr_o,
    output logic mem_bank_o,
    output logic mem_re_o,
    output logic mem_we_o,
    output logic [15:0] mem_wdata_o,
    input wire logic [15:0] mem_rdata_i
);

    bbrm_state_e state_q;
    bbrm_word_t tbl_q [0:`BBRM_TBL_WORDS-1];
    logic [4:0] fidx_q;
    logic [15:0] line_q;
    logic [12:0] wi_q;
    bbrm_word_t s0_q;
    bbrm_word_t s1_q;

    bbrm_comb_if cif ();

    bbrm_combine u_combine (
        .cif(cif.comb)
    );

    // Table fields.
    wire [15:0] fn_w = tbl_q[`BBRM_TBL_FUNC];
    wire [15:0] dbase = tbl_q[`BBRM_TBL_DBASE];
    wire [15:0] drast = tbl_q[`BBRM_TBL_DRAST];
    wire [15:0] dest_left_x = tbl_q[`BBRM_TBL_DLX];
    wire [15:0] dest_top_y = tbl_q[`BBRM_TBL_DTY];
    wire [15:0] dwid = tbl_q[`BBRM_TBL_DW];
    wire [15:0] dhgt = tbl_q[`BBRM_TBL_DH];
    wire [15:0] sbase = tbl_q[`BBRM_TBL_SBASE];
    wire [15:0] srast = tbl_q[`BBRM_TBL_SRAST];
    wire [15:0] src_left_x = tbl_q[`BBRM_TBL_SLX];
    wire [15:0] src_top_y = tbl_q[`BBRM_TBL_STY];
    wire [1:0] src_sel = fn_w[`BBRM_FN_SEL_HI:`BBRM_FN_SEL_LO];
    wire [1:0] op_sel = fn_w[`BBRM_FN_OP_HI:`BBRM_FN_OP_LO];
    wire src_bank = fn_w[`BBRM_FN_SRC_BANK];
    wire dst_bank = fn_w[`BBRM_FN_DST_BANK];
    wire src_used = (src_sel != `BBRM_SEL_PAT);

    // A zero extent is treated like a negative one: there is nothing to write.
    wire neg_extent = dwid[15] | dhgt[15];
    wire zero_extent = (dwid == 16'h0000) | (dhgt == 16'h0000);
    wire empty_blk = neg_extent | zero_extent;

    // Vertical order: walk away from the part of the source about to be overwritten.
    wire bottom_up = (dest_top_y > src_top_y);
    wire [15:0] ypos = bottom_up ? (dhgt - 16'h0001 - line_q) : line_q;

    // Horizontal span in destination words.
    wire [16:0] dend_bit = {1'b0, dest_left_x} + {1'b0, dwid} - 17'h00001;
    wire [12:0] first_w = {1'b0, dest_left_x[15:4]};
    wire [12:0] last_w = dend_bit[16:4];
    wire [12:0] span_w = last_w - first_w;
    // Same line, source to the left: go right to left so no source word is clobbered early.
    wire rev_x = src_used && (dest_top_y == src_top_y) && (dest_left_x > src_left_x);
    wire [12:0] col = rev_x ? (last_w - wi_q) : (first_w + wi_q);
    wire last_word = (wi_q == span_w);

    // Destination word address.
    // Row products wrap at 16 bits, as every address sum here does.
    wire [15:0] d_row = dest_top_y + ypos;
    wire [15:0] d_line = dbase + d_row * drast;
    wire [15:0] d_addr = d_line + {3'h0, col};

    // Source bit of the destination word's first bit; source extent is the destination's.
    wire [16:0] d_off = {col, 4'h0} - {1'b0, dest_left_x};
    wire [16:0] sbit = {1'b0, src_left_x} + d_off;
    wire [15:0] s_word = {{3{sbit[16]}}, sbit[16:4]};
    wire [15:0] s_row = src_top_y + ypos;
    wire [15:0] s_line = sbase + s_row * srast;
    wire [15:0] s_addr = s_line + s_word;
    wire [31:0] funnel = {s0_q, s1_q} << sbit[3:0];
    wire [15:0] src_al = funnel[31:16];

    // Edge masks for partial words.
    wire [15:0] head_m = (col == first_w) ? (16'hFFFF >> dest_left_x[3:0]) : 16'hFFFF;
    wire signed [15:0] tail_sh = $signed(16'h8000) >>> dend_bit[3:0];
    wire [15:0] tail_m = (col == last_w) ? tail_sh : 16'hFFFF;

    // Pattern word chosen by processing order, so it rotates per line handled.
    wire [3:0] pat_idx = 4'(`BBRM_TBL_PAT0) + {2'h0, line_q[1:0]};

    assign cif.src = src_al;
    assign cif.dst = mem_rdata_i;
    assign cif.pat = tbl_q[pat_idx];
    assign cif.mask = head_m & tail_m;
    assign cif.src_sel = src_sel;
    assign cif.op = op_sel;

    wire [15:0] tbl_addr = table_ptr_acc_o + {11'h000, fidx_q};
    wire fetch_issue = (fidx_q < 5'(`BBRM_TBL_WORDS));
    wire fetch_cap = (fidx_q >= 5'h02);
    wire fetch_end = (fidx_q == `BBRM_FETCH_LAST);
    wire [3:0] cap_idx = 4'(fidx_q - 5'h02);
    wire line_done = (line_q == dhgt);
    // Start is taken only while idle; a start during an operation is ignored.
    wire go = start_i && (state_q == ST_IDLE);
    wire accept = go && wcs_present_i;
    wire refuse = go && !wcs_present_i;
    // A request still pending at resume stops the engine again before any word moves,
    // so software must dismiss it first; there is no forward-progress guarantee.
    wire line_exit = line_done || irq_pending_i;
    wire end_empty = (state_q == ST_CHECK) && empty_blk;
    wire end_line = (state_q == ST_LINE) && line_exit;
    wire [15:0] line_inc = line_q + 16'h0001;
    wire [12:0] wi_inc = wi_q + 13'h0001;
    wire [15:0] s_addr_next = s_addr + 16'h0001;

    // Sequencer. A block-source word takes five cycles and each line one more, which
    // leaves ample margin under the rough per-word and per-line cycle targets.
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            state_q <= ST_IDLE;
            fidx_q <= 5'h00;
            line_q <= `BBRM_WORD_RST;
            wi_q <= 13'h0000;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (accept) begin
                        state_q <= ST_FETCH;
                        fidx_q <= 5'h00;
                        line_q <= progress_acc_i;
                    end
                end
                ST_FETCH: begin
                    fidx_q <= fidx_q + 5'h01;
                    if (fetch_end) begin
                        state_q <= ST_CHECK;
                    end
                end
                ST_CHECK: state_q <= empty_blk ? ST_IDLE : ST_LINE;
                ST_LINE: begin
                    wi_q <= 13'h0000;
                    if (line_exit) begin
                        state_q <= ST_IDLE;
                    end else begin
                        state_q <= src_used ? ST_SRC0 : ST_DST;
                    end
                end
                ST_SRC0: state_q <= ST_SRC1;
                ST_SRC1: state_q <= ST_DST;
                ST_DST: state_q <= ST_WAIT;
                ST_WAIT: state_q <= ST_WRITE;
                ST_WRITE: begin
                    if (last_word) begin
                        line_q <= line_inc;
                        state_q <= ST_LINE;
                    end else begin
                        wi_q <= wi_inc;
                        state_q <= src_used ? ST_SRC0 : ST_DST;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Table words land two cycles after their read is issued.
    always_ff @(posedge mclk_i) begin
        if (state_q == ST_FETCH && fetch_cap) begin
            tbl_q[cap_idx] <= mem_rdata_i;
        end
    end

    // The two source words form the funnel that aligns source bits to the destination.
    always_ff @(posedge mclk_i) begin
        if (state_q == ST_DST) begin
            s0_q <= mem_rdata_i;
        end
    end

    // The second word arrives one cycle later, while the destination read is under way.
    always_ff @(posedge mclk_i) begin
        if (state_q == ST_WAIT) begin
            s1_q <= mem_rdata_i;
        end
    end

    // Memory port, one strobe cycle per access; back-to-back reads hold mem_re_o high.
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            mem_addr_o <= `BBRM_WORD_RST;
            mem_bank_o <= 1'b0;
            mem_re_o <= 1'b0;
            mem_we_o <= 1'b0;
            mem_wdata_o <= `BBRM_WORD_RST;
        end else begin
            mem_re_o <= 1'b0;
            mem_we_o <= 1'b0;
            unique case (state_q)
                ST_FETCH: begin
                    mem_re_o <= fetch_issue;
                    mem_addr_o <= tbl_addr;
                    mem_bank_o <= 1'b0;
                end
                ST_SRC0: begin
                    mem_re_o <= 1'b1;
                    mem_addr_o <= s_addr;
                    mem_bank_o <= src_bank;
                end
                ST_SRC1: begin
                    mem_re_o <= 1'b1;
                    mem_addr_o <= s_addr_next;
                    mem_bank_o <= src_bank;
                end
                ST_DST: begin
                    mem_re_o <= 1'b1;
                    mem_addr_o <= d_addr;
                    mem_bank_o <= dst_bank;
                end
                ST_WRITE: begin
                    mem_we_o <= 1'b1;
                    mem_addr_o <= d_addr;
                    mem_bank_o <= dst_bank;
                    mem_wdata_o <= cif.res;
                end
                default: begin
                end
            endcase
        end
    end

    // Completion pulses, one cycle each.
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            done_o <= 1'b0;
            trap_o <= 1'b0;
            pc_backup_o <= 1'b0;
        end else begin
            done_o <= end_empty || (end_line && line_done);
            trap_o <= refuse;
            pc_backup_o <= end_line && !line_done;
        end
    end

    // Busy rises the cycle after the accepted start and falls as the closing pulse rises.
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            busy_o <= 1'b0;
        end else if (accept) begin
            busy_o <= 1'b1;
        end else if (end_empty || end_line) begin
            busy_o <= 1'b0;
        end
    end

    // Accumulators.
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            progress_acc_o <= `BBRM_WORD_RST;
            table_ptr_acc_o <= `BBRM_WORD_RST;
        end else if (accept) begin
            table_ptr_acc_o <= table_ptr_acc_i;
            progress_acc_o <= progress_acc_i;
        end else if (end_line) begin
            // After completion of a non-empty block the progress accumulator is left holding the line count.
            progress_acc_o <= line_q;
        end
    end

endmodule : bbrm_top

// File: testbench/bbrm_top_properties.sv
module bbrm_top_checker (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // Instruction port.
    input wire logic start_i,
    input wire logic wcs_present_i,
    input wire logic irq_pending_i,
    input wire logic busy_o,
    input wire logic done_o,
    input wire logic trap_o,
    input wire logic pc_backup_o,
    input wire logic [15:0] table_ptr_acc_o,
    // Memory port.
    input wire logic [15:0] mem_addr_o,
    input wire logic mem_bank_o,
    input wire logic mem_re_o,
    input wire logic mem_we_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!reset_n_i);

    trap_on_absent_a: assert property (
        start_i && !busy_o && !wcs_present_i |=> trap_o && !busy_o)
        else $error("missing control store did not trap");
    trap_no_work_a: assert property (trap_o |-> !mem_re_o && !mem_we_o)
        else $error("trap cycle touched memory");
    start_runs_a: assert property (
        start_i && !busy_o && wcs_present_i |=> busy_o && !trap_o)
        else $error("accepted start did not raise busy");
    table_fetch_a: assert property ($rose(busy_o) |-> ##1 (mem_re_o && !mem_bank_o)[*8])
        else $error("table fetch not a run of main bank reads");
    table_addr_a: assert property ($rose(busy_o) |->
        ##1 mem_addr_o == table_ptr_acc_o ##1 mem_addr_o == table_ptr_acc_o + 16'h0001)
        else $error("table fetch address wrong");
    ptr_kept_a: assert property (busy_o && $past(busy_o) |-> $stable(table_ptr_acc_o))
        else $error("table pointer changed during operation");
    end_drops_busy_a: assert property (
        done_o || pc_backup_o |-> !busy_o && $past(busy_o))
        else $error("end pulse without busy falling");
    irq_cause_a: assert property (
        pc_backup_o |-> $past(irq_pending_i) || $past(irq_pending_i, 2))
        else $error("backup pulse without interrupt");
    write_in_op_a: assert property (mem_we_o |-> busy_o)
        else $error("memory write outside operation");
endmodule : bbrm_top_checker

bind bbrm_top bbrm_top_checker bbrm_top_checker_i (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .start_i(start_i),
    .wcs_present_i(wcs_present_i),
    .irq_pending_i(irq_pending_i),
    .busy_o(busy_o),
    .done_o(done_o),
    .trap_o(trap_o),
    .pc_backup_o(pc_backup_o),
    .table_ptr_acc_o(table_ptr_acc_o),
    .mem_addr_o(mem_addr_o),
    .mem_bank_o(mem_bank_o),
    .mem_re_o(mem_re_o),
    .mem_we_o(mem_we_o)
);

// File: testbench/bbrm_mem_model.sv
module bbrm_mem_model (
    // Clock.
    input wire logic mclk_i,
    // Engine side.
    input wire logic [15:0] mem_addr_i,
    input wire logic mem_bank_i,
    input wire logic mem_re_i,
    input wire logic mem_we_i,
    input wire logic [15:0] mem_wdata_i,
    output logic [15:0] mem_rdata_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // Only 512 words per bank are modelled; higher address bits alias.
    logic [15:0] bank_q [2][512];
    initial mem_rdata_o = 16'h0000;
    always @(posedge mclk_i) begin
        if (mem_we_i) begin
            bank_q[mem_bank_i][mem_addr_i[8:0]] <= mem_wdata_i;
        end
        // Data is valid only after a read; otherwise the bus keeps toggling.
        if (mem_re_i) begin
            mem_rdata_o <= bank_q[mem_bank_i][mem_addr_i[8:0]];
        end else begin
            mem_rdata_o <= ~mem_rdata_o;
        end
    end
endmodule : bbrm_mem_model

// File: testbench/tb_bit_block_raster_mover.sv
module tb_bit_block_raster_mover;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic start = 1'b0;
    logic wcs = 1'b1;
    logic irq = 1'b0;
    logic [15:0] prog = 16'h0000;
    logic [15:0] tptr = 16'h0100;
    logic busy_o, done_o, trap_o, pc_backup_o, mem_bank_o, mem_re_o, mem_we_o;
    logic [15:0] progress_acc_o, table_ptr_acc_o, mem_addr_o, mem_wdata_o, rdata;
    logic [15:0] wcount = 16'h0000;
    logic [15:0] nw_base = 16'h0000;
    wire [15:0] nw = wcount - nw_base;
    logic [2:0] ev;
    int num_errors = 0;
    int n_compared = 0;
    int cyc = 0;

    bbrm_top bbrm_top_i (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .start_i(start),
        .wcs_present_i(wcs), .irq_pending_i(irq), .progress_acc_i(prog),
        .table_ptr_acc_i(tptr), .busy_o(busy_o), .done_o(done_o), .trap_o(trap_o),
        .pc_backup_o(pc_backup_o), .progress_acc_o(progress_acc_o),
        .table_ptr_acc_o(table_ptr_acc_o), .mem_addr_o(mem_addr_o),
        .mem_bank_o(mem_bank_o), .mem_re_o(mem_re_o), .mem_we_o(mem_we_o),
        .mem_wdata_o(mem_wdata_o), .mem_rdata_i(rdata));
    bbrm_mem_model bbrm_mem_model_i (.mclk_i(mclk_i), .mem_addr_i(mem_addr_o),
        .mem_bank_i(mem_bank_o), .mem_re_i(mem_re_o), .mem_we_i(mem_we_o),
        .mem_wdata_i(mem_wdata_o), .mem_rdata_o(rdata));

    initial forever #25 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        if (mem_we_o === 1'b1) wcount <= wcount + 16'h0001;
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("Compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    task automatic mw(input logic b, input int a, input logic [15:0] v);
        bbrm_mem_model_i.bank_q[b][a] = v;
    endtask : mw

    function automatic logic [15:0] mr(input logic b, input int a);
        return bbrm_mem_model_i.bank_q[b][a];
    endfunction : mr

    // Words 0 to 11 of the table; the pattern words are loaded with mw.
    task automatic put_table(input logic [15:0] v [12]);
        for (int i = 0; i < 12; i++) mw(1'b0, 256 + i, v[i]);
    endtask : put_table

    // Pulses start and waits for the first of done, backup or trap.
    task automatic go(input logic [15:0] p);
        nw_base = wcount;
        @(posedge mclk_i);
        prog <= p;
        start <= 1'b1;
        @(posedge mclk_i);
        start <= 1'b0;
        ev = 3'h0;
        for (int k = 0; k < 3000 && ev === 3'h0; k++) begin
            @(negedge mclk_i);
            ev = {trap_o, pc_backup_o, done_o};
        end
    endtask : go

    task automatic t_trap();
        wcs <= 1'b0;
        go(16'h0000);
        chk({13'h0, ev}, 16'h0004);
        chk(nw, 16'h0000);
        @(posedge mclk_i);
        wcs <= 1'b1;
    endtask : t_trap

    task automatic t_noop();
        for (int n = 0; n < 2; n++) begin
            put_table('{0, 0, 16'h0010, 1, 0, 0, n ? 16 : 16'hFFFF, n ? 16'hFFFF : 1,
                16'h0020, 1, 0, 0});
            go(16'h0000);
            chk({13'h0, ev}, 16'h0001);
            chk(nw, 16'h0000);
        end
    endtask : t_noop

    task automatic t_ops();
        logic [15:0] s, sv, r;
        for (int op = 0; op < 4; op++) begin
            for (int sel = 0; sel < 4; sel++) begin
                mw(0, 16'h10, 16'h5A3C);
                mw(1, 16'h10, 16'h5A3C);
                mw(0, 16'h20, 16'hC3F0);
                mw(1, 16'h20, 16'h96E1);
                mw(0, 268, 16'h33CC);
                sv = op[0] ? 16'h96E1 : 16'hC3F0;
                s = sel == 0 ? sv : sel == 1 ? ~sv : sel == 2 ? sv & 16'h33CC : 16'h33CC;
                r = op == 0 ? s : op == 1 ? s | 16'h5A3C : op == 2 ? s ^ 16'h5A3C
                    : ~s & 16'h5A3C;
                // Bits 15 to 6 stay zero.
                put_table('{{10'h0, op[0], sel[0], sel[1:0], op[1:0]}, 0, 16'h0010, 1, 0, 0,
                    16, 1, 16'h0020, 1, 0, 0});
                go(16'h0000);
                chk(mr(sel[0], 16'h10), r);
                chk(mr(~sel[0], 16'h10), 16'h5A3C);
                chk(nw, 16'h0001);
            end
        end
        chk(table_ptr_acc_o, 16'h0100);
    endtask : t_ops

    task automatic t_lines();
        // Raw pattern words, left unphased, so the checks see the processing order itself.
        for (int k = 0; k < 4; k++) mw(0, 268 + k, 16'h1111 << k);
        for (int d = 0; d < 2; d++) begin
            put_table('{16'h000C, 0, 16'h0040, 1, 0, d, 16, 5, 16'h0040, 1, 0, 0});
            go(16'h0000);
            for (int i = 0; i < 5; i++) begin
                chk(mr(0, 16'h40 + d + i), 16'h1111 << (d ? (4 - i) % 4 : i % 4));
            end
        end
    endtask : t_lines

    task automatic t_irq();
        put_table('{16'h000C, 0, 16'h0078, 1, 0, 0, 16, 3, 16'h0078, 1, 0, 0});
        @(posedge mclk_i);
        irq <= 1'b1;
        go(16'h0000);
        chk({13'h0, ev}, 16'h0002);
        chk(nw, 16'h0000);
        @(posedge mclk_i);
        irq <= 1'b0;
        go(progress_acc_o);
        chk({13'h0, ev}, 16'h0001);
        chk(progress_acc_o, 16'h0003);
        chk(nw, 16'h0003);
    endtask : t_irq

    task automatic t_edges();
        mw(0, 16'h50, 16'hAAAA);
        mw(0, 268, 16'hFFFF);
        put_table('{16'h000C, 0, 16'h0050, 1, 4, 0, 8, 1, 16'h0050, 1, 0, 0});
        go(16'h0000);
        chk(mr(0, 16'h50), 16'hAFFA);
        mw(0, 16'h60, 16'h1234);
        mw(0, 16'h61, 16'h5678);
        put_table('{0, 0, 16'h0068, 1, 0, 0, 16, 1, 16'h0060, 1, 4, 0});
        go(16'h0000);
        chk(mr(0, 16'h68), 16'h2345);
        for (int k = 0; k < 4; k++) mw(0, 16'h70 + k, 16'h1111 * (k + 1));
        put_table('{0, 0, 16'h0070, 4, 16, 0, 32, 1, 16'h0070, 4, 0, 0});
        go(16'h0000);
        chk(mr(0, 16'h71), 16'h1111);
        chk(mr(0, 16'h72), 16'h2222);
    endtask : t_edges

    initial begin
        repeat (20) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        t_trap();
        t_noop();
        t_ops();
        t_lines();
        t_irq();
        t_edges();
        tally_and_finish();
    end
endmodule : tb_bit_block_raster_mover
